//--- pkg/mmad_pkg.sv
// Purpose: Constants and types for the mode latch and address decoder
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes: Register offsets are the printed byte addresses in the 64K space
package mmad_pkg;
  localparam logic [15:0] SYSCTL_ADDR = 16'hffc4;
  localparam logic [15:0] MODEST_ADDR = 16'hffc5;
  localparam logic [7:0] MODEST_FIXED = 8'he4;
  localparam logic [7:0] SYSCTL_RESET = 8'h09;
  localparam logic [7:0] SYSCTL_WMASK = 8'hf7;
  localparam logic [7:0] SYSCTL_ONES = 8'h08;
  localparam int INTERNAL_RAM_ENABLE_BIT = 0;
  localparam int SHARED_RAM_ENABLE_BIT = 1;
  localparam logic [15:0] ROM_LAST = 16'h3fff;
  localparam logic [15:0] RAM_FIRST = 16'hfd80;
  localparam logic [15:0] RAM_LAST = 16'hff7f;
  localparam logic [15:0] GAP0_FIRST = 16'hff80;
  localparam logic [15:0] GAP0_LAST = 16'hff8f;
  localparam logic [15:0] GAP1_FIRST = 16'hffa8;
  localparam logic [15:0] GAP1_LAST = 16'hffaf;
  localparam logic [7:0] IO_PAGE = 8'hff;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [1:0] CYC_WORD = 2'd2;
  localparam logic [1:0] CYC_REGF = 2'd3;
  localparam logic [1:0] CYC_EXT = 2'd3;

  typedef enum logic [1:0] {
    MMAD_MODE0 = 2'b00,
    MMAD_MODE1 = 2'b01,
    MMAD_MODE2 = 2'b10,
    MMAD_MODE3 = 2'b11
  } mmad_mode_e;

  typedef enum logic [2:0] {
    MMAD_T_ROM = 3'b000,
    MMAD_T_RAM = 3'b001,
    MMAD_T_REG = 3'b010,
    MMAD_T_EXT = 3'b011,
    MMAD_T_VOID = 3'b100
  } mmad_tgt_e;

  typedef enum logic [1:0] {
    MMAD_IDLE = 2'b00,
    MMAD_BUSY = 2'b01,
    MMAD_WAIT = 2'b10
  } mmad_state_e;

  // Processor access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmad_req_s;

  // Port usage flags for the pin multiplexers
  typedef struct packed {
    logic p12_addr;
    logic p12_addr_out_by_ddr;
    logic p3_data;
    logic bus_ctrl;
    logic p3_shared_data;
    logic p8_shared_sel;
    logic p9_shared_if;
  } mmad_pins_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] sysctl;
    mmad_state_e state;
    mmad_tgt_e tgt;
    logic [1:0] cnt;
    logic done;
    logic [7:0] rdata;
    logic was_rst;
  } mmad_st_s;
endpackage

//--- design/mmad_decode.sv
// Purpose: Mode latch, address decode, access timing and control registers
// Assumes: Requests are held stable until done_out pulses
// Notes: Memory arrays live elsewhere; this block steers and times accesses
`timescale 1ns/1ps
module mmad_decode
  import mmad_pkg::*;
#(
  parameter bit NO_ROM_VARIANT = 1'b0
)
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic mode_pin_high_in,
  input wire logic mode_pin_low_in,
  input wire mmad_req_s req_in,
  input wire logic ext_wait_in,
  input wire logic [7:0] ext_rdata_in,
  input wire logic [7:0] onchip_rdata_in,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic io_page_select_n_out,
  output logic ext_access_out,
  output logic ext_rd_out,
  output logic ext_wr_out,
  output logic rom_sel_out,
  output logic ram_sel_out,
  output logic regf_sel_out,
  output logic word_access_out,
  output logic [1:0] latched_mode_out,
  output logic internal_ram_enable_out,
  output logic shared_ram_enable_out,
  output logic shared_ram_ext_open_out,
  output mmad_pins_s pins_out
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // Classify an address by latched mode and RAM enable
  function automatic mmad_tgt_e classify(input logic [15:0] a, input logic [1:0] md,
                                         input logic internal_ram_enable);
    logic exp;
    exp = (md == MMAD_MODE1) || (md == MMAD_MODE2);
    if (md == MMAD_MODE0)
      classify = MMAD_T_VOID;
    else if (exp && (in_rng(a, GAP0_FIRST, GAP0_LAST) || in_rng(a, GAP1_FIRST, GAP1_LAST)))
      classify = MMAD_T_EXT;
    else if (in_rng(a, RAM_FIRST, RAM_LAST))
      classify = internal_ram_enable ? MMAD_T_RAM : (exp ? MMAD_T_EXT : MMAD_T_VOID);
    else if (a >= GAP0_FIRST)
      classify = MMAD_T_REG;
    else if ((md != MMAD_MODE1) && (a <= ROM_LAST))
      classify = MMAD_T_ROM;
    else if (exp)
      classify = MMAD_T_EXT;
    else
      classify = MMAD_T_VOID;
  endfunction

  function automatic logic [1:0] cycles_of(input mmad_tgt_e t);
    case (t)
      MMAD_T_ROM, MMAD_T_RAM: cycles_of = CYC_WORD;
      MMAD_T_EXT: cycles_of = CYC_EXT;
      default: cycles_of = CYC_REGF;
    endcase
  endfunction

  mmad_st_s st_reg;
  mmad_st_s st_next;
  mmad_tgt_e cur_tgt;
  logic [1:0] eff_pins;
  logic exp_mode;
  logic io_page;
  logic [7:0] modest_val;
  logic [7:0] reg_rd;

  // ----------------------------------------
  // Combinational view
  // ----------------------------------------
  // No-ROM variant is forced into mode 1 whatever the pins show
  assign eff_pins = NO_ROM_VARIANT ? 2'(MMAD_MODE1)
                                   : {mode_pin_high_in, mode_pin_low_in};
  assign exp_mode = (st_reg.mode == MMAD_MODE1) || (st_reg.mode == MMAD_MODE2);
  assign cur_tgt = classify(req_in.addr, st_reg.mode, st_reg.sysctl[INTERNAL_RAM_ENABLE_BIT]);
  assign io_page = req_in.valid && (req_in.addr[15:8] == IO_PAGE);
  assign modest_val = MODEST_FIXED | {6'h00, st_reg.mode};
  assign reg_rd = (req_in.addr == SYSCTL_ADDR) ? st_reg.sysctl
                : (req_in.addr == MODEST_ADDR) ? modest_val : 8'h00;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.was_rst = 1'b0;
    // Mode captured on the first clock after reset release
    if (st_reg.was_rst)
      st_next.mode = eff_pins;
    case (st_reg.state)
      MMAD_IDLE:
      begin
        // A request still held while done shows is the one just served, not a new one
        if (req_in.valid && !st_reg.was_rst && !st_reg.done)
        begin
          st_next.tgt = cur_tgt;
          st_next.cnt = cycles_of(cur_tgt) - 2'd1;
          st_next.state = MMAD_BUSY;
        end
      end
      MMAD_BUSY:
      begin
        if (st_reg.cnt > 2'd1)
          st_next.cnt = st_reg.cnt - 2'd1;
        else if ((st_reg.tgt == MMAD_T_EXT) && ext_wait_in)
          st_next.state = MMAD_WAIT;
        else
        begin
          st_next.done = 1'b1;
          st_next.state = MMAD_IDLE;
          case (st_reg.tgt)
            MMAD_T_EXT: st_next.rdata = ext_rdata_in;
            MMAD_T_REG: st_next.rdata = reg_rd;
            MMAD_T_VOID: st_next.rdata = ALL_ONES;
            default: st_next.rdata = onchip_rdata_in;
          endcase
          // Writes land in the last cycle; only writable bits change
          if (req_in.write && (st_reg.tgt == MMAD_T_REG) && (req_in.addr == SYSCTL_ADDR))
            st_next.sysctl = (req_in.wdata & SYSCTL_WMASK) | SYSCTL_ONES;
        end
      end
      MMAD_WAIT:
      begin
        if (!ext_wait_in)
        begin
          st_next.done = 1'b1;
          st_next.rdata = ext_rdata_in;
          st_next.state = MMAD_IDLE;
        end
      end
      default: st_next.state = MMAD_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // RAM enable resets to one and is only changed by writes
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      st_reg.mode <= 2'(MMAD_MODE0);
      st_reg.sysctl <= SYSCTL_RESET;
      st_reg.state <= MMAD_IDLE;
      st_reg.tgt <= MMAD_T_VOID;
      st_reg.cnt <= 2'd0;
      st_reg.done <= 1'b0;
      st_reg.rdata <= 8'h00;
      st_reg.was_rst <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign done_out = st_reg.done;
  assign rdata_out = st_reg.rdata;
  assign io_page_select_n_out = !io_page;
  assign ext_access_out = (st_reg.state != MMAD_IDLE) && (st_reg.tgt == MMAD_T_EXT);
  assign ext_rd_out = ext_access_out && !req_in.write;
  assign ext_wr_out = ext_access_out && req_in.write;
  assign rom_sel_out = (st_reg.state == MMAD_BUSY) && (st_reg.tgt == MMAD_T_ROM);
  assign ram_sel_out = (st_reg.state == MMAD_BUSY) && (st_reg.tgt == MMAD_T_RAM);
  assign regf_sel_out = (st_reg.state == MMAD_BUSY) && (st_reg.tgt == MMAD_T_REG);
  assign word_access_out = rom_sel_out || ram_sel_out;
  assign latched_mode_out = st_reg.mode;
  assign internal_ram_enable_out = st_reg.sysctl[INTERNAL_RAM_ENABLE_BIT];
  assign shared_ram_enable_out = st_reg.sysctl[SHARED_RAM_ENABLE_BIT];
  // External master reaches shared RAM only in single-chip mode
  assign shared_ram_ext_open_out = (st_reg.mode == MMAD_MODE3) && st_reg.sysctl[SHARED_RAM_ENABLE_BIT];

  // Pin usage per mode
  assign pins_out.p12_addr = (st_reg.mode == MMAD_MODE1);
  assign pins_out.p12_addr_out_by_ddr = (st_reg.mode == MMAD_MODE2);
  assign pins_out.p3_data = exp_mode;
  assign pins_out.bus_ctrl = exp_mode;
  assign pins_out.p3_shared_data = shared_ram_ext_open_out;
  assign pins_out.p8_shared_sel = shared_ram_ext_open_out;
  assign pins_out.p9_shared_if = shared_ram_ext_open_out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_start;
    st_reg.state == MMAD_IDLE && req_in.valid && !st_reg.was_rst && !st_reg.done;
  endsequence

  a_mode_capture: assert property (@(posedge clock_in) disable iff (srst_in)
    !srst_in && st_reg.was_rst |=> latched_mode_out == $past(eff_pins))
    else $error("mode not captured");
  a_mode_hold: assert property (@(posedge clock_in) disable iff (srst_in)
    !st_reg.was_rst |=> $stable(latched_mode_out))
    else $error("mode changed");
  a_word_time: assert property (@(posedge clock_in) disable iff (srst_in)
    s_start ##0 (cur_tgt == MMAD_T_RAM) |=> ##1 done_out)
    else $error("word access not two cycles");
  a_reg_time: assert property (@(posedge clock_in) disable iff (srst_in)
    s_start ##0 (cur_tgt == MMAD_T_REG) |=> !done_out ##1 !done_out ##1 done_out)
    else $error("register access not three cycles");
  a_ext_min: assert property (@(posedge clock_in) disable iff (srst_in)
    s_start ##0 (cur_tgt == MMAD_T_EXT) |=> !done_out [*2])
    else $error("external cycle too short");
  a_void_ones: assert property (@(posedge clock_in) disable iff (srst_in)
    done_out && $past(st_reg.tgt) == MMAD_T_VOID |-> rdata_out == ALL_ONES)
    else $error("off-chip read not all ones");
  a_io_strobe: assert property (@(posedge clock_in) disable iff (srst_in)
    req_in.valid && req_in.addr >= 16'hff00 |-> !io_page_select_n_out)
    else $error("io strobe missing");
  a_gap_ext: assert property (@(posedge clock_in) disable iff (srst_in)
    exp_mode && in_rng(req_in.addr, GAP1_FIRST, GAP1_LAST) |-> cur_tgt == MMAD_T_EXT)
    else $error("gap not external");
  a_modest_bits: assert property (@(posedge clock_in) disable iff (srst_in)
    done_out && (st_reg.tgt == MMAD_T_REG) && req_in.valid && !req_in.write
      && (req_in.addr == MODEST_ADDR) |-> rdata_out == {6'b111001, latched_mode_out})
    else $error("mode register read wrong");
  a_shared_closed: assert property (@(posedge clock_in) disable iff (srst_in)
    exp_mode |-> !shared_ram_ext_open_out)
    else $error("shared RAM open in expanded mode");
  a_rom_off: assert property (@(posedge clock_in) disable iff (srst_in)
    st_reg.mode == MMAD_MODE1 |-> cur_tgt != MMAD_T_ROM)
    else $error("ROM used in mode 1");
  a_bit3_one: assert property (@(posedge clock_in) disable iff (srst_in)
    st_reg.sysctl[3])
    else $error("reserved bit not one");
endmodule

//--- verif/mmad_ext_mem.sv
// Purpose: Behavioural external memory and I/O on the expanded bus
// Assumes: Byte wide; data is driven only while ext_rd_in is high
// Notes: A released bus shows the inverse of the last data, so stale reads fail
`timescale 1ns/1ps
module mmad_ext_mem
  import mmad_pkg::*;
(
  input wire logic clock_in,
  input wire mmad_req_s req_in,
  input wire logic ext_access_in,
  input wire logic ext_rd_in,
  input wire logic ext_wr_in,
  input wire logic slow_in,
  output logic ext_wait_out,
  output logic [7:0] ext_rdata_out
);
  logic [7:0] mem [256];
  logic [7:0] last_reg;
  logic [2:0] cnt_reg;
  // ------------------------------------------------------------
  // Storage, wait request and bus drive
  // ------------------------------------------------------------
  // Known fill pattern: each byte is its low address xor a5
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'ha5;
    last_reg = 8'h00;
    cnt_reg = 3'h0;
  end
  // Slow device asks for two extra cycles from the last base cycle
  assign ext_wait_out = slow_in && ext_access_in && (cnt_reg >= 3'h1) && (cnt_reg < 3'h3);
  always @(posedge clock_in)
  begin
    cnt_reg <= ext_access_in ? cnt_reg + 3'h1 : 3'h0;
    if (ext_wr_in)
      mem[req_in.addr[7:0]] <= req_in.wdata;
    if (ext_rd_in)
      last_reg <= mem[req_in.addr[7:0]];
  end
  // Released bus never repeats the last byte
  assign ext_rdata_out = ext_rd_in ? mem[req_in.addr[7:0]] : ~last_reg;
endmodule

//--- verif/mmad_tb.sv
// Purpose: Register and decode tests of the mode latch in all four modes
// Assumes: Access latencies as handed over; requests driven on rising edges
// Notes: A second decoder is built as the no-ROM variant and only its mode is checked
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench
  import mmad_pkg::*;
;
  localparam logic [4:0] S_ROM = 5'h11, S_RAM = 5'h09, S_REG = 5'h04, S_EXT = 5'h02;
  logic clock_in, srst_in, mode_pin_high_in, mode_pin_low_in, slow, ext_wait;
  logic done_out, io_n, ext_access, ext_rd, ext_wr, rom_sel, ram_sel, regf_sel, word;
  logic internal_ram_enable, shared_ram_enable, ext_open;
  logic [7:0] ext_rdata, rdata_out;
  logic [1:0] lmode, nr_mode;
  logic [4:0] seen;
  mmad_req_s req_in;
  mmad_pins_s pins;
  int errors, checked, n;
  // ------------------------------------------------------------
  // Design, far side and observation
  // ------------------------------------------------------------
  mmad_decode DUT (.clock_in(clock_in), .srst_in(srst_in), .mode_pin_high_in(mode_pin_high_in),
    .mode_pin_low_in(mode_pin_low_in), .req_in(req_in), .ext_wait_in(ext_wait),
    .ext_rdata_in(ext_rdata), .onchip_rdata_in(8'h3c), .done_out(done_out),
    .rdata_out(rdata_out), .io_page_select_n_out(io_n), .ext_access_out(ext_access),
    .ext_rd_out(ext_rd), .ext_wr_out(ext_wr), .rom_sel_out(rom_sel), .ram_sel_out(ram_sel),
    .regf_sel_out(regf_sel), .word_access_out(word), .latched_mode_out(lmode),
    .internal_ram_enable_out(internal_ram_enable), .shared_ram_enable_out(shared_ram_enable),
    .shared_ram_ext_open_out(ext_open), .pins_out(pins));
  mmad_ext_mem ext_mem (.clock_in(clock_in), .req_in(req_in), .ext_access_in(ext_access),
    .ext_rd_in(ext_rd), .ext_wr_in(ext_wr), .slow_in(slow), .ext_wait_out(ext_wait),
    .ext_rdata_out(ext_rdata));
  // No-ROM variant sees the same pins but must always latch mode 1
  mmad_decode #(.NO_ROM_VARIANT(1'b1)) DUT_NOROM (.clock_in(clock_in), .srst_in(srst_in),
    .mode_pin_high_in(mode_pin_high_in), .mode_pin_low_in(mode_pin_low_in), .req_in(req_in),
    .ext_wait_in(1'b0), .ext_rdata_in(8'h00), .onchip_rdata_in(8'h00), .done_out(),
    .rdata_out(), .io_page_select_n_out(), .ext_access_out(), .ext_rd_out(), .ext_wr_out(),
    .rom_sel_out(), .ram_sel_out(), .regf_sel_out(), .word_access_out(),
    .latched_mode_out(nr_mode), .internal_ram_enable_out(), .shared_ram_enable_out(),
    .shared_ram_ext_open_out(), .pins_out());
  // Collect which targets were selected while a request is up
  always @(posedge clock_in)
    seen <= req_in.valid ? seen | {rom_sel, ram_sel, regf_sel, ext_access, word} : 5'h00;
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Reset with given pins, then flip the pins just after they are latched
  task automatic rst(input logic hi, input logic lo);
    @(posedge clock_in);
    srst_in <= 1'b1;
    mode_pin_high_in <= hi;
    mode_pin_low_in <= lo;
    repeat (3) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    mode_pin_high_in <= ~hi;
    mode_pin_low_in <= ~lo;
  endtask
  // One access of fixed latency; valid drops on the edge that samples done high
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
    input int lat, input logic [4:0] sel, input logic [7:0] exp);
    @(posedge clock_in);
    req_in <= '{1'b1, wr, a, d};
    @(posedge clock_in);
    #1;
    `CHK(io_n, (a[15:8] != 8'hff))
    repeat (lat - 1) @(posedge clock_in);
    #1;
    `CHK(done_out, 1'b1)
    `CHK(seen, sel)
    if (!wr)
      `CHK(rdata_out, exp)
    // Request stands until the edge that samples done, then it is released
    @(posedge clock_in);
    req_in.valid <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    errors = 0;
    checked = 0;
    slow = 1'b0;
    srst_in = 1'b1;
    mode_pin_high_in = 1'b0;
    mode_pin_low_in = 1'b0;
    req_in = '0;
    // Single-chip mode
    rst(1'b1, 1'b1);
    acc(1'b0, MODEST_ADDR, 8'h00, 3, S_REG, 8'he7);
    `CHK({lmode, nr_mode}, 4'hd)
    acc(1'b1, MODEST_ADDR, 8'h18, 3, S_REG, 8'h00);
    acc(1'b0, MODEST_ADDR, 8'h00, 3, S_REG, 8'he7);
    acc(1'b0, SYSCTL_ADDR, 8'h00, 3, S_REG, 8'h09);
    acc(1'b1, SYSCTL_ADDR, 8'hf2, 3, S_REG, 8'h00);
    acc(1'b0, SYSCTL_ADDR, 8'h00, 3, S_REG, 8'hfa);
    `CHK({ext_open, internal_ram_enable, pins.p12_addr}, 3'h4)
    `CHK({pins.p3_shared_data, pins.p8_shared_sel, pins.p9_shared_if}, 3'h7)
    acc(1'b0, 16'hfd80, 8'h00, 3, 5'h00, 8'hff);
    acc(1'b0, 16'h0100, 8'h00, 2, S_ROM, 8'h3c);
    $display("test single_chip finished");
    // Expanded mode without ROM
    rst(1'b0, 1'b1);
    acc(1'b0, MODEST_ADDR, 8'h00, 3, S_REG, 8'he5);
    `CHK({pins.p12_addr, pins.p3_data, pins.bus_ctrl, shared_ram_enable}, 4'he)
    acc(1'b0, 16'h0000, 8'h00, 3, S_EXT, 8'ha5);
    acc(1'b1, 16'h1234, 8'h5a, 3, S_EXT, 8'h00);
    acc(1'b0, 16'h1234, 8'h00, 3, S_EXT, 8'h5a);
    acc(1'b0, 16'hfd80, 8'h00, 2, S_RAM, 8'h3c);
    acc(1'b0, 16'hff80, 8'h00, 3, S_EXT, 8'h25);
    acc(1'b0, 16'hffaf, 8'h00, 3, S_EXT, 8'h0a);
    // Software clears the RAM enable as it would before hardware standby
    acc(1'b1, SYSCTL_ADDR, 8'h02, 3, S_REG, 8'h00);
    `CHK({ext_open, shared_ram_enable, internal_ram_enable}, 3'h2)
    acc(1'b0, 16'hfd80, 8'h00, 3, S_EXT, 8'h25);
    // Slow device: two wait cycles on top of the three-cycle basic access
    @(posedge clock_in);
    slow <= 1'b1;
    req_in <= '{1'b1, 1'b0, 16'h0003, 8'h00};
    n = 0;
    do
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    while (done_out !== 1'b1 && n < 20);
    `CHK(n, 5)
    `CHK(rdata_out, 8'ha6)
    @(posedge clock_in);
    req_in.valid <= 1'b0;
    slow <= 1'b0;
    $display("test expanded_no_rom finished");
    // Expanded mode with ROM
    rst(1'b1, 1'b0);
    acc(1'b0, MODEST_ADDR, 8'h00, 3, S_REG, 8'he6);
    acc(1'b0, SYSCTL_ADDR, 8'h00, 3, S_REG, 8'h09);
    acc(1'b0, 16'h3fff, 8'h00, 2, S_ROM, 8'h3c);
    acc(1'b0, 16'h4000, 8'h00, 3, S_EXT, 8'ha5);
    `CHK(pins.p12_addr_out_by_ddr, 1'b1)
    $display("test expanded_rom finished");
    // Programming mode: nothing answers
    rst(1'b0, 1'b0);
    acc(1'b0, 16'h0000, 8'h00, 3, 5'h00, 8'hff);
    $display("test programming_mode finished");
    print_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    #20000;
    errors++;
    print_verdict();
  end
endmodule
